// ==== scm_pkg.sv ====
// Package of register map, field layout, reset values and state codes for the system clock source mux.
package scm_pkg;
	localparam logic [11:0] SYS_CTL_ADDR = 12'h000;
	localparam logic [11:0] LOOP_CTL_ADDR = 12'h004;
	localparam logic [11:0] STATUS_ADDR = 12'h008;
	localparam int SEL_LSB = 0;
	localparam int BYPASS_BIT = 0;
	localparam int OSC_INT_BIT = 1;
	localparam int DIV_LSB = 16;
	localparam int DIV_W = 10;
	localparam int ST_ACT_SEL_LSB = 0;
	localparam int ST_ACT_BYPASS_BIT = 2;
	localparam int ST_ACT_OSC_BIT = 3;
	localparam int ST_BUSY_BIT = 4;
	localparam int ST_PLL_EN_BIT = 5;
	localparam int ST_ACT_DIV_LSB = 16;
	localparam logic [1:0] SEL_WAKEUP = 2'h0;
	localparam logic [1:0] SEL_RESERVED = 2'h1;
	localparam logic [1:0] SEL_PLL_PRESCALE = 2'h2;
	localparam logic [1:0] SEL_DIRECT = 2'h3;
	localparam logic [1:0] RST_SEL = 2'h0;
	localparam logic RST_BYPASS = 1'b1;
	localparam logic RST_OSC_INT = 1'b1;
	localparam logic [9:0] RST_DIV = 10'h000;
	localparam logic [9:0] DIV_MAX = 10'h3ff;
	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_HOLD = 3'b010,
		ST_ALIGN = 3'b100
	} scm_state_t;
endpackage : scm_pkg

// ==== scm_divider.sv ====
// Output divider that counts rising edges of the selected source level.
`timescale 1ns/10ps
`default_nettype none
module scm_divider (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Source and control.
	input wire logic src,
	input wire logic clr,
	input wire logic [9:0] setting,
	// Divided level.
	output logic level
);
	typedef struct packed {
		logic prev;
		logic [9:0] cnt;
	} scm_div_regs_t;

	scm_div_regs_t r;
	scm_div_regs_t next_r;
	logic rise;

	assign rise = src & ~r.prev;
	// A setting of zero passes the source straight through.
	assign level = (setting == 10'h000) ? src : (r.cnt <= (setting >> 1));

	always_comb begin
		next_r = r;
		next_r.prev = src;
		if (clr) begin
			next_r.cnt = setting;
		end else if (rise) begin
			next_r.cnt = (r.cnt >= setting) ? 10'h000 : r.cnt + 10'h001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_div_wrap: assert property ((rise && !clr && setting != 10'h000 && r.cnt == setting) |=> (level || $changed(setting)))
		else $error("divider did not start a high phase on wrap");
	chk_div_range: assert property (clr || setting == 10'h000 || r.cnt <= setting || $changed(setting))
		else $error("divider count beyond setting");
endmodule : scm_divider
`default_nettype wire

// ==== scm_clock_mux.sv ====
// System clock source mux and prescaler with an APB register file.
//
// Summary of operation
// - Source select code 11 takes the system clock straight from the direct clock input, duty cycle and all.
// - Code 10 with the bypass bit set runs prescaler mode from the crystal or the internal oscillator.
// - In prescaler mode the system clock is the oscillator divided by the divider setting plus one.
// - A divide factor of one passes the oscillator through so its duty cycle is kept.
// - The divider reaches a factor of 1024 at its largest setting.
// - Code 10 with the bypass bit clear enables the PLL and uses its output as the system clock.
// - Code 00 uses the wakeup oscillator directly with no division.
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module scm_clock_mux (
	// APB clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Clock source levels.
	input wire logic direct_clock_input,
	input wire logic crystal_input,
	input wire logic internal_osc_input,
	input wire logic wakeup_osc_input,
	input wire logic pll_clock_input,
	// Clock outputs.
	output logic pll_enable,
	output logic system_clock
);
	typedef struct packed {
		scm_pkg::scm_state_t state;
		logic [1:0] sel;
		logic bypass;
		logic osc_int;
		logic [9:0] div;
		logic [1:0] act_sel;
		logic act_bypass;
		logic act_osc_int;
		logic [9:0] act_div;
		logic sys_clock;
		logic pll_en;
		logic [31:0] prdata;
	} scm_regs_t;

	scm_regs_t r;
	scm_regs_t next_r;
	logic src_level;
	logic div_level;
	logic [9:0] eff_div;
	logic setup;
	logic wr;
	logic mapped;
	logic cfg_changed;

	// Picks the raw source level for a configuration.
	function automatic logic pick_source(input logic [1:0] sel, input logic bypass, input logic osc_int,
		input logic dir, input logic xtal, input logic intosc, input logic wu, input logic pll);
		logic v;
		v = wu;
		case (sel)
			scm_pkg::SEL_DIRECT: begin
				v = dir;
			end
			scm_pkg::SEL_PLL_PRESCALE: begin
				if (bypass) begin
					v = osc_int ? intosc : xtal;
				end else begin
					v = pll;
				end
			end
			default: begin
				v = wu;
			end
		endcase
		return v;
	endfunction : pick_source

	// The divider applies only in prescaler mode.
	function automatic logic [9:0] pick_div(input logic [1:0] sel, input logic bypass, input logic [9:0] div);
		return (sel == scm_pkg::SEL_PLL_PRESCALE && bypass) ? div : 10'h000;
	endfunction : pick_div

	assign src_level = pick_source(r.act_sel, r.act_bypass, r.act_osc_int, direct_clock_input, crystal_input,
		internal_osc_input, wakeup_osc_input, pll_clock_input);
	assign eff_div = pick_div(r.act_sel, r.act_bypass, r.act_div);

	scm_divider u_div (
		.pclk(pclk),
		.presetn(presetn),
		.src(src_level),
		.clr(r.state == scm_pkg::ST_ALIGN),
		.setting(eff_div),
		.level(div_level)
	);

	assign setup = psel & ~penable;
	assign mapped = (paddr == scm_pkg::SYS_CTL_ADDR) || (paddr == scm_pkg::LOOP_CTL_ADDR) ||
		(paddr == scm_pkg::STATUS_ADDR);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign wr = psel & penable & pwrite & mapped;
	assign prdata = r.prdata;
	assign pll_enable = r.pll_en;
	assign system_clock = r.sys_clock;
	assign cfg_changed = (r.sel != r.act_sel) || (r.bypass != r.act_bypass) || (r.osc_int != r.act_osc_int) ||
		(r.div != r.act_div);

	always_comb begin
		next_r = r;
		if (wr && paddr == scm_pkg::SYS_CTL_ADDR) begin
			next_r.sel = pwdata[scm_pkg::SEL_LSB +: 2];
		end
		if (wr && paddr == scm_pkg::LOOP_CTL_ADDR) begin
			next_r.bypass = pwdata[scm_pkg::BYPASS_BIT];
			next_r.osc_int = pwdata[scm_pkg::OSC_INT_BIT];
			next_r.div = pwdata[scm_pkg::DIV_LSB +: scm_pkg::DIV_W];
		end
		next_r.pll_en = (next_r.sel == scm_pkg::SEL_PLL_PRESCALE) && !next_r.bypass;
		if (setup) begin
			next_r.prdata = 32'h00000000;
			case (paddr)
				scm_pkg::SYS_CTL_ADDR: begin
					next_r.prdata[scm_pkg::SEL_LSB +: 2] = r.sel;
				end
				scm_pkg::LOOP_CTL_ADDR: begin
					next_r.prdata[scm_pkg::BYPASS_BIT] = r.bypass;
					next_r.prdata[scm_pkg::OSC_INT_BIT] = r.osc_int;
					next_r.prdata[scm_pkg::DIV_LSB +: scm_pkg::DIV_W] = r.div;
				end
				scm_pkg::STATUS_ADDR: begin
					next_r.prdata[scm_pkg::ST_ACT_SEL_LSB +: 2] = r.act_sel;
					next_r.prdata[scm_pkg::ST_ACT_BYPASS_BIT] = r.act_bypass;
					next_r.prdata[scm_pkg::ST_ACT_OSC_BIT] = r.act_osc_int;
					next_r.prdata[scm_pkg::ST_BUSY_BIT] = (r.state != scm_pkg::ST_RUN);
					next_r.prdata[scm_pkg::ST_PLL_EN_BIT] = r.pll_en;
					next_r.prdata[scm_pkg::ST_ACT_DIV_LSB +: scm_pkg::DIV_W] = r.act_div;
				end
				default: begin
					next_r.prdata = 32'h00000000;
				end
			endcase
		end
		case (r.state)
			scm_pkg::ST_RUN: begin
				next_r.sys_clock = div_level;
				if (cfg_changed) begin
					next_r.state = scm_pkg::ST_HOLD;
				end
			end
			scm_pkg::ST_HOLD: begin
				// Let a running high phase finish, but never start a new one before parking low.
				next_r.sys_clock = div_level & r.sys_clock;
				if (!(div_level && r.sys_clock)) begin
					next_r.sys_clock = 1'b0;
					next_r.act_sel = r.sel;
					next_r.act_bypass = r.bypass;
					next_r.act_osc_int = r.osc_int;
					next_r.act_div = r.div;
					next_r.state = scm_pkg::ST_ALIGN;
				end
			end
			scm_pkg::ST_ALIGN: begin
				// Wait for the new source to sit low so the first phase is whole.
				next_r.sys_clock = 1'b0;
				if (!src_level) begin
					next_r.state = scm_pkg::ST_RUN;
				end
			end
			default: begin
				next_r.sys_clock = 1'b0;
				next_r.state = scm_pkg::ST_ALIGN;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r.state <= scm_pkg::ST_ALIGN;
			r.sel <= scm_pkg::RST_SEL;
			r.bypass <= scm_pkg::RST_BYPASS;
			r.osc_int <= scm_pkg::RST_OSC_INT;
			r.div <= scm_pkg::RST_DIV;
			r.act_sel <= scm_pkg::RST_SEL;
			r.act_bypass <= scm_pkg::RST_BYPASS;
			r.act_osc_int <= scm_pkg::RST_OSC_INT;
			r.act_div <= scm_pkg::RST_DIV;
			r.sys_clock <= 1'b0;
			r.pll_en <= 1'b0;
			r.prdata <= 32'h00000000;
		end else begin
			r <= next_r;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic run;
	assign run = (r.state == scm_pkg::ST_RUN) && !cfg_changed;

	chk_direct_follow: assert property ((run && r.act_sel == scm_pkg::SEL_DIRECT)
		|=> system_clock == $past(direct_clock_input))
		else $error("direct drive clock does not follow input");
	chk_prescale_xtal: assert property ((run && r.act_sel == scm_pkg::SEL_PLL_PRESCALE && r.act_bypass
		&& !r.act_osc_int && r.act_div == 10'h000) |=> system_clock == $past(crystal_input))
		else $error("prescaler does not pass crystal clock");
	chk_prescale_int: assert property ((run && r.act_sel == scm_pkg::SEL_PLL_PRESCALE && r.act_bypass
		&& r.act_osc_int && r.act_div == 10'h000) |=> system_clock == $past(internal_osc_input))
		else $error("factor one does not pass internal oscillator");
	chk_div_in_use: assert property ((run && !(r.act_sel == scm_pkg::SEL_PLL_PRESCALE && r.act_bypass))
		|-> (div_level == src_level))
		else $error("divide factor applied outside prescaler mode");
	chk_div_max: assert property ((wr && paddr == scm_pkg::LOOP_CTL_ADDR
		&& pwdata[scm_pkg::DIV_LSB +: scm_pkg::DIV_W] == scm_pkg::DIV_MAX)
		|=> r.div == scm_pkg::DIV_MAX)
		else $error("maximum divider setting not held");
	chk_pll_follow: assert property ((run && r.act_sel == scm_pkg::SEL_PLL_PRESCALE && !r.act_bypass)
		|-> pll_enable ##1 (system_clock == $past(pll_clock_input)))
		else $error("pll output not used or not enabled");
	chk_wakeup_follow: assert property ((run && r.act_sel == scm_pkg::SEL_WAKEUP)
		|=> system_clock == $past(wakeup_osc_input))
		else $error("wakeup clock not passed directly");
	chk_align_low: assert property ((r.state == scm_pkg::ST_ALIGN) |-> !system_clock)
		else $error("clock not parked low while aligning");
	chk_rise_in_run: assert property ($rose(system_clock) |-> $past(r.state) == scm_pkg::ST_RUN)
		else $error("clock rose during a source switch");
	chk_hold_no_rise: assert property ((r.state == scm_pkg::ST_HOLD && !system_clock) |=> !system_clock)
		else $error("new high phase started while holding");
	chk_align_exit: assert property ((r.state == scm_pkg::ST_ALIGN && !src_level) |=> (r.state == scm_pkg::ST_RUN))
		else $error("clock did not restart once new source was low");
	chk_bad_addr: assert property ((psel && penable) |-> (pslverr == !mapped))
		else $error("slave error on wrong address");

	cov_direct: cover property (run && r.act_sel == scm_pkg::SEL_DIRECT && $rose(system_clock));
	cov_prescale: cover property (run && eff_div != 10'h000 && $rose(system_clock));
	cov_pll: cover property (run && r.act_sel == scm_pkg::SEL_PLL_PRESCALE && !r.act_bypass);
	cov_switch: cover property (r.state == scm_pkg::ST_HOLD ##1 r.state == scm_pkg::ST_ALIGN);
endmodule : scm_clock_mux
`default_nettype wire

// ==== scm_osc_model.sv ====
// Behavioural clock sources for the mux, each toggling at its own fixed rate.
`timescale 1ns/10ps
`default_nettype none
module scm_osc_model #(
	parameter int H_DIR = 3,
	parameter int H_XTAL = 4,
	parameter int H_INT = 5,
	parameter int H_WU = 6,
	parameter int H_PLL = 2
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Source levels.
	output logic direct_clock_input,
	output logic crystal_input,
	output logic internal_osc_input,
	output logic wakeup_osc_input,
	output logic pll_clock_input
);
	localparam int HALF [5] = '{H_DIR, H_XTAL, H_INT, H_WU, H_PLL};
	int cnt [5];
	logic [4:0] lvl;
	assign direct_clock_input = lvl[0];
	assign crystal_input = lvl[1];
	assign internal_osc_input = lvl[2];
	assign wakeup_osc_input = lvl[3];
	assign pll_clock_input = lvl[4];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lvl <= 5'h00;
			for (int i = 0; i < 5; i++) begin
				cnt[i] <= 0;
			end
		end else begin
			for (int i = 0; i < 5; i++) begin
				if (cnt[i] == HALF[i] - 1) begin
					cnt[i] <= 0;
					lvl[i] <= ~lvl[i];
				end else begin
					cnt[i] <= cnt[i] + 1;
				end
			end
		end
	end
endmodule : scm_osc_model
`default_nettype wire

// ==== tb_top.sv ====
// Testbench that programs the clock mux over APB and measures the system clock.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pll_enable, system_clock, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic dci, xi, ioi, wi, pli;
	int n_fail, checked, run_len;
	scm_osc_model osc (.pclk(pclk), .presetn(presetn), .direct_clock_input(dci), .crystal_input(xi),
		.internal_osc_input(ioi), .wakeup_osc_input(wi), .pll_clock_input(pli));
	scm_clock_mux uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.direct_clock_input(dci), .crystal_input(xi), .internal_osc_input(ioi), .wakeup_osc_input(wi),
		.pll_clock_input(pli), .pll_enable(pll_enable), .system_clock(system_clock));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			chk("pready", {31'h0, pready}, 32'h1);
			report_and_stop();
		end
	endtask : apb
	task automatic wait_lvl(input logic v, output int n);
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while (system_clock !== v && n < 20000);
		if (system_clock !== v) begin
			chk("system_clock level", {31'h0, system_clock}, {31'h0, v});
			report_and_stop();
		end
	endtask : wait_lvl
	task automatic run(input string name, input logic [1:0] sel, input logic [31:0] lc, input int per, input int hi);
		int d, h, l, i;
		logic [31:0] exp;
		exp = {6'h0, lc[25:16], 11'h0, 1'b0, lc[1], lc[0], sel};
		apb(1'b1, scm_pkg::LOOP_CTL_ADDR, lc, rd, err);
		apb(1'b1, scm_pkg::SYS_CTL_ADDR, {30'h0, sel}, rd, err);
		apb(1'b0, scm_pkg::LOOP_CTL_ADDR, 32'h0, rd, err);
		chk("loop_control_reg", rd, lc);
		i = 0;
		do begin
			apb(1'b0, scm_pkg::STATUS_ADDR, 32'h0, rd, err);
			i++;
		end while ((rd & 32'h03ff_001f) !== exp && i < 5000);
		chk("status", rd & 32'h03ff_001f, exp);
		if ((rd & 32'h03ff_001f) !== exp) report_and_stop();
		wait_lvl(1'b0, d);
		wait_lvl(1'b1, d);
		wait_lvl(1'b0, h);
		wait_lvl(1'b1, l);
		chk({name, " period"}, 32'(h + l), 32'(per));
		chk({name, " high"}, 32'(h), 32'(hi));
		chk("pll_enable", {31'h0, pll_enable}, {31'h0, sel == 2'h2 && lc[0] == 1'b0});
		$display("test %s done", name);
	endtask : run
	always @(posedge pclk) begin
		#1;
		if (system_clock === 1'b1) begin
			run_len++;
		end else begin
			if (run_len == 1) chk("high pulse", 32'h1, 32'h2);
			run_len = 0;
		end
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		n_fail = 0;
		checked = 0;
		run_len = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, scm_pkg::SYS_CTL_ADDR, 32'h0, rd, err);
		chk("system_control_reg reset", rd, 32'h0);
		apb(1'b0, scm_pkg::LOOP_CTL_ADDR, 32'h0, rd, err);
		chk("loop_control_reg reset", rd, 32'h3);
		apb(1'b0, 12'h00c, 32'h0, rd, err);
		chk("unmapped error", {31'h0, err}, 32'h1);
		chk("unmapped data", rd, 32'h0);
		apb(1'b1, scm_pkg::STATUS_ADDR, 32'hffff_ffff, rd, err);
		chk("status write error", {31'h0, err}, 32'h0);
		apb(1'b0, scm_pkg::STATUS_ADDR, 32'h0, rd, err);
		chk("status write ignored", rd, 32'h0000_000c);
		$display("test registers done");
		run("wakeup", 2'h0, 32'h3, 12, 6);
		run("reserved", 2'h1, 32'h3, 12, 6);
		run("direct", 2'h3, 32'h3, 6, 3);
		run("internal", 2'h2, 32'h3, 10, 5);
		run("crystal", 2'h2, 32'h0001_0001, 16, 8);
		run("maximum", 2'h2, 32'h03ff_0001, 8192, 4096);
		run("pll", 2'h2, 32'h0000_0000, 4, 2);
		run("back to direct", 2'h3, 32'h3, 6, 3);
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
